//--- common/irq_pkg.sv
// constants shared by the interrupt controller and its pin edge detector
package irq_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_CTRL_FIRST = 8'h00;
  localparam logic [7:0] OFS_EDGE_SEL = 8'h04;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h08;
  localparam logic [7:0] OFS_CTRL_THREE = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // word index of each register (offset / 4)
  localparam int REG_FIRST = 0;
  localparam int REG_EDGE = 1;
  localparam int REG_TWO = 2;
  localparam int REG_THREE = 3;
  localparam int REG_STATUS = 4;
  localparam int NUM_REG = 5;

  localparam int REG_W = 8;
  localparam logic [7:0] REG_RESET = 8'h00;

  // sources; a lower index has the higher priority
  localparam int NUM_SRC = 6;
  localparam int SRC_W = 3;
  localparam int SRC_EXT = 0;
  localparam int SRC_TBASE0 = 1;
  localparam int SRC_EEPROM = 2;
  localparam int SRC_CMPA = 3;
  localparam int SRC_CMPP = 4;
  localparam int SRC_TBASE1 = 5;

  // register holding each source's flag and enable, and the bit positions
  localparam int SRC_REG [NUM_SRC] = '{0, 2, 2, 2, 2, 3};
  localparam int FLAG_POS [NUM_SRC] = '{4, 7, 6, 5, 4, 4};
  localparam int EN_POS [NUM_SRC] = '{1, 3, 2, 1, 0, 0};
  localparam int GIE_POS = 0;

  // edge select field, low two bits of the edge register
  localparam int EDGE_LSB = 0;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // status register bits
  localparam int ST_WAKE = 0;
  localparam int ST_STACK_FULL = 1;
  localparam int ST_SRC_LSB = 4;

  // vector addresses, one distinct word per source
  localparam int PC_W = 13;
  localparam logic [12:0] VEC_ADDR [NUM_SRC] =
    '{13'h0004, 13'h0008, 13'h000c, 13'h0010, 13'h0014, 13'h0018};

endpackage : irq_pkg

//--- src/ext_edge_detect.sv
// edge detector for the external interrupt pin
`timescale 1ns/1ps

module ext_edge_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_level,
  input wire logic [1:0] edge_sel,
  output logic edge_evt
);

  logic prev_ff;
  logic armed_ff;
  logic rise;
  logic fall;

  // no edge is reported on the first sample after reset, so a pulled-up
  // pin does not fire a false rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      prev_ff <= pin_level;
      armed_ff <= 1'b1;
    end
  end

  assign rise = armed_ff && pin_level && !prev_ff;
  assign fall = armed_ff && !pin_level && prev_ff;

  always_comb begin
    case (edge_sel)
      irq_pkg::EDGE_RISE: edge_evt = rise;
      irq_pkg::EDGE_FALL: edge_evt = fall;
      irq_pkg::EDGE_BOTH: edge_evt = rise || fall;
      default: edge_evt = 1'b0;
    endcase
  end

  a_edge_off_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    edge_sel == irq_pkg::EDGE_OFF |-> !edge_evt)
    else $error("edge event while edge select is off");

  a_edge_rise_seen: assert property (
    @(posedge pclk) disable iff (!presetn)
    (edge_sel == irq_pkg::EDGE_RISE && $rose(pin_level) && armed_ff)
      |-> edge_evt)
    else $error("rising edge missed");

endmodule : ext_edge_detect

//--- src/irq_controller.sv
// interrupt controller: flags, enables, priority, vectoring, apb registers
`timescale 1ns/1ps

// How it works
// - ext two register: time base 0 flag bit 7, enable bit 3
// - ext two register: eeprom flag bit 6, enable bit 2
// - ext two register: comparator a flag bit 5, enable bit 1
// - ext two register: comparator p flag bit 4, enable bit 0
// - ext three register: time base 1 flag bit 4, enable bit 0, rest zero
// - an event sets its flag whatever its enable says
// - a flag whose enable is low never causes a vector jump
// - global enable low suppresses every interrupt
// - taking an interrupt pushes next pc and loads the source vector
// - return from interrupt pops the saved pc
// - each source has its own distinct vector
// - servicing clears the global enable, so no nesting until software sets it again
// - flags still set and hold while interrupts are blocked
// - no interrupt is acknowledged while the stack is full
// - simultaneous requests are served in a fixed priority order
// - any set flag wakes the device from sleep or idle
// - selected edge on the external pin sets the external flag
// - servicing the external interrupt clears its flag
// - edge select offers rising, falling, both, or disabled
// - pull-high selection stays in force on the external pin
// - edge field: 00 off, 01 rise, 10 fall, 11 both
// - first register: global enable bit 0, pin enable 1, pin flag 4
module irq_controller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  input wire logic ext_pin_level,
  input wire logic pull_high_sel,
  output logic pull_high_en_ff,
  input wire logic tbase0_evt,
  input wire logic eeprom_evt,
  input wire logic cmpa_evt,
  input wire logic cmpp_evt,
  input wire logic tbase1_evt,
  input wire logic core_boundary,
  input wire logic stack_full,
  input wire logic [irq_pkg::PC_W-1:0] next_pc,
  input wire logic return_from_irq_instr,
  output logic irq_take_ff,
  output logic [irq_pkg::PC_W-1:0] irq_vector_ff,
  output logic [irq_pkg::PC_W-1:0] push_pc_ff,
  output logic stack_pop_ff,
  output logic wake_ff
);

  localparam int NS = irq_pkg::NUM_SRC;
  localparam int SW = irq_pkg::SRC_W;

  logic [NS-1:0] flag_ff;
  logic [NS-1:0] en_ff;
  logic gie_ff;
  logic [1:0] edge_sel_ff;
  logic [SW-1:0] irq_src_ff;
  logic stack_full_seen_ff;

  logic [NS-1:0] src_evt;
  logic ext_evt;
  logic [NS-1:0] pend;
  logic any_pend;
  logic [SW-1:0] take_idx;
  logic take;
  logic xfer_done;
  logic wr_done;
  logic [2:0] reg_sel;
  logic mapped;
  logic [irq_pkg::REG_W-1:0] rd_reg [irq_pkg::NUM_REG];

  ////////////////////////////////////////////////////////////////////////
  // external pin

  ext_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin_level(ext_pin_level),
    .edge_sel(edge_sel_ff),
    .edge_evt(ext_evt)
  );

  assign src_evt = {tbase1_evt, cmpp_evt, cmpa_evt, eeprom_evt, tbase0_evt,
                    ext_evt};

  // pull-high keeps working while the pin serves as interrupt input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_high_en_ff <= 1'b0;
    end else begin
      pull_high_en_ff <= pull_high_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, writes land at the completing edge

  assign xfer_done = psel && penable && pready_ff;
  // refused addresses must not alias onto a register through paddr[4:2]
  assign wr_done = xfer_done && pwrite && mapped;
  assign reg_sel = paddr[4:2];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[7:5] == 3'h0) &&
                  (reg_sel < 3'(irq_pkg::NUM_REG));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !mapped;
      if (psel && penable && !pready_ff && !pwrite && mapped) begin
        prdata_ff <= {24'h00_0000, rd_reg[reg_sel]};
      end else begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // read view; unimplemented bits stay zero
  always_comb begin
    for (int r = 0; r < irq_pkg::NUM_REG; r++) begin
      rd_reg[r] = 8'h00;
    end
    for (int i = 0; i < NS; i++) begin
      rd_reg[irq_pkg::SRC_REG[i]][irq_pkg::FLAG_POS[i]] = flag_ff[i];
      rd_reg[irq_pkg::SRC_REG[i]][irq_pkg::EN_POS[i]] = en_ff[i];
    end
    rd_reg[irq_pkg::REG_FIRST][irq_pkg::GIE_POS] = gie_ff;
    rd_reg[irq_pkg::REG_EDGE][irq_pkg::EDGE_LSB +: 2] = edge_sel_ff;
    rd_reg[irq_pkg::REG_STATUS][irq_pkg::ST_WAKE] = wake_ff;
    rd_reg[irq_pkg::REG_STATUS][irq_pkg::ST_STACK_FULL] = stack_full_seen_ff;
    rd_reg[irq_pkg::REG_STATUS][irq_pkg::ST_SRC_LSB +: SW] = irq_src_ff;
  end

  ////////////////////////////////////////////////////////////////////////
  // per-source flags and enables

  for (genvar i = 0; i < NS; i++) begin : g_src
    logic wr_hit;
    assign wr_hit = wr_done && (reg_sel == 3'(irq_pkg::SRC_REG[i]));

    // event beats both software clear and service clear, so none is lost
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_ff[i] <= 1'b0;
      end else if (src_evt[i]) begin
        flag_ff[i] <= 1'b1;
      end else if (wr_hit) begin
        flag_ff[i] <= pwdata[irq_pkg::FLAG_POS[i]];
      end else if (take && take_idx == SW'(i)) begin
        flag_ff[i] <= 1'b0;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        en_ff[i] <= 1'b0;
      end else if (wr_hit) begin
        en_ff[i] <= pwdata[irq_pkg::EN_POS[i]];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_sel_ff <= irq_pkg::EDGE_OFF;
    end else if (wr_done && reg_sel == 3'(irq_pkg::REG_EDGE)) begin
      edge_sel_ff <= pwdata[irq_pkg::EDGE_LSB +: 2];
    end
  end

  // service wins over a write in the same cycle to keep nesting out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_ff <= 1'b0;
    end else if (take) begin
      gie_ff <= 1'b0;
    end else if (wr_done && reg_sel == 3'(irq_pkg::REG_FIRST)) begin
      gie_ff <= pwdata[irq_pkg::GIE_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // arbitration and vectoring

  assign pend = flag_ff & en_ff;

  always_comb begin
    any_pend = 1'b0;
    take_idx = '0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (pend[i]) begin
        any_pend = 1'b1;
        take_idx = SW'(i);
      end
    end
  end

  assign take = core_boundary && gie_ff && !stack_full && any_pend;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_take_ff <= 1'b0;
      irq_vector_ff <= '0;
      push_pc_ff <= '0;
      irq_src_ff <= '0;
    end else begin
      irq_take_ff <= take;
      if (take) begin
        irq_vector_ff <= irq_pkg::VEC_ADDR[take_idx];
        push_pc_ff <= next_pc;
        irq_src_ff <= take_idx;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_pop_ff <= 1'b0;
    end else begin
      stack_pop_ff <= return_from_irq_instr;
    end
  end

  // any flag wakes, enabled or not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_ff <= 1'b0;
      stack_full_seen_ff <= 1'b0;
    end else begin
      wake_ff <= |flag_ff;
      stack_full_seen_ff <= stack_full && gie_ff && any_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  a_take_needs_gie: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_take_ff |-> $past(gie_ff) && $past(core_boundary))
    else $error("interrupt taken with global enable low");

  a_take_needs_en: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_take_ff |-> |($past(pend) & (NS'(1) << irq_src_ff)))
    else $error("interrupt taken for a disabled source");

  a_stack_full_block: assert property (
    @(posedge pclk) disable iff (!presetn)
    stack_full |=> !irq_take_ff)
    else $error("interrupt taken while stack full");

  a_gie_cleared: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_take_ff |-> !gie_ff)
    else $error("global enable still set after service");

  a_flag_cleared: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_take_ff && !(|($past(src_evt) & (NS'(1) << irq_src_ff)))
      |-> !flag_ff[irq_src_ff])
    else $error("serviced flag not cleared");

  a_event_sets_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    |src_evt |=> (flag_ff & $past(src_evt)) == $past(src_evt))
    else $error("event did not set its flag");

  a_vector_match: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_take_ff |-> irq_vector_ff == irq_pkg::VEC_ADDR[irq_src_ff]
                    && push_pc_ff == $past(next_pc))
    else $error("wrong vector or pushed pc");

  a_priority_held: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_take_ff |-> ($past(pend) & ((NS'(1) << irq_src_ff) - NS'(1))) == '0)
    else $error("lower priority source served first");

  a_wake_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    |flag_ff |=> wake_ff)
    else $error("set flag did not raise wake");

  a_pop_on_return: assert property (
    @(posedge pclk) disable iff (!presetn)
    return_from_irq_instr |=> stack_pop_ff)
    else $error("return did not pop");

  a_three_reserved: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_reg[irq_pkg::REG_THREE] & 8'hee) == 8'h00)
    else $error("reserved bits of ext three not zero");

  c_take: cover property (@(posedge pclk) disable iff (!presetn)
    irq_take_ff);
  c_blocked_full: cover property (@(posedge pclk) disable iff (!presetn)
    gie_ff && any_pend && core_boundary && stack_full);
  c_ext_taken: cover property (@(posedge pclk) disable iff (!presetn)
    irq_take_ff && irq_src_ff == SW'(irq_pkg::SRC_EXT));
  c_nest: cover property (@(posedge pclk) disable iff (!presetn)
    irq_take_ff ##[1:20] irq_take_ff);

endmodule : irq_controller

//--- tb/core_model.sv
// behavioural core sequencer and return stack for the interrupt controller
`timescale 1ns/1ps

module core_model #(
  parameter int DEPTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic boundary_en,
  input wire logic ret_req,
  input wire logic irq_take_ff,
  input wire logic stack_pop_ff,
  output logic core_boundary,
  output logic stack_full,
  output logic return_from_irq_instr
);
  logic [3:0] depth_ff;

  ////////////////////////////////////////////////////////////////////////////
  // take and pop in one cycle leave the depth as it was
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_ff <= 4'h0;
    end else begin
      depth_ff <= depth_ff + 4'(irq_take_ff) - 4'(stack_pop_ff);
    end
  end

  assign stack_full = (depth_ff == 4'(DEPTH));
  // boundary low stands for a slow core stuck in a long instruction
  assign core_boundary = boundary_en;
  assign return_from_irq_instr = ret_req;
endmodule : core_model

//--- tb/testbench.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps

module testbench;
  logic pclk, presetn, psel, penable, pwrite, ext_pin_level, pull_high_sel;
  logic [7:0] paddr, f, n, g;
  logic [31:0] pwdata, prdata_ff;
  logic pready_ff, pslverr_ff, pull_high_en_ff, core_boundary, stack_full;
  logic [5:0] evt;
  logic [12:0] next_pc, irq_vector_ff, push_pc_ff, v;
  logic return_from_irq_instr, irq_take_ff, stack_pop_ff, wake_ff;
  logic boundary_en, ret_req;
  logic [9:0] apb_q[$], e;
  logic [25:0] take_q[$], t;
  int error_cnt, tests_run, cyc, seed, r;

  irq_controller dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata_ff, .pready_ff, .pslverr_ff, .ext_pin_level,
    .pull_high_sel, .pull_high_en_ff, .tbase0_evt(evt[1]),
    .eeprom_evt(evt[2]), .cmpa_evt(evt[3]), .cmpp_evt(evt[4]),
    .tbase1_evt(evt[5]), .core_boundary, .stack_full, .next_pc,
    .return_from_irq_instr, .irq_take_ff, .irq_vector_ff, .push_pc_ff,
    .stack_pop_ff, .wake_ff);
  core_model core_u (.pclk, .presetn, .boundary_en, .ret_req, .irq_take_ff,
    .stack_pop_ff, .core_boundary, .stack_full, .return_from_irq_instr);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic cmp(input string nm, input logic [31:0] x, y);
    tests_run++;
    if (y !== x) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, x, y);
    end
  endtask : cmp

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  // result watcher: oldest note against each answer
  always @(posedge pclk) begin
    if (pready_ff === 1'b1) begin
      e = (apb_q.size() > 0) ? apb_q.pop_front() : 10'h1ff;
      cmp("pslverr", {31'h0, e[8]}, {31'h0, pslverr_ff});
      if (!e[9]) cmp("prdata", {24'h0, e[7:0]}, prdata_ff);
    end
    if (irq_take_ff === 1'b1) begin
      t = (take_q.size() > 0) ? take_q.pop_front() : 26'h3ffffff;
      cmp("vector", {19'h0, t[25:13]}, {19'h0, irq_vector_ff});
      cmp("pushed pc", {19'h0, t[12:0]}, {19'h0, push_pc_ff});
    end
    cyc++;
    if (cyc == 6000) begin
      cmp("timeout", 32'h0, 32'h1);
      final_report();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, d, x);
    logic err;
    err = (a > 8'h10) || (a[1:0] != 2'h0);
    apb_q.push_back({wr, err, err ? 8'h00 : x});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_ff !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input int i, input logic [7:0] d);
    apb(1'b1, 8'(i * 4), d, 8'h00);
  endtask : wr

  task automatic rd(input int i, input logic [7:0] x);
    apb(1'b0, 8'(i * 4), 8'h00, x);
  endtask : rd

  task automatic fire(input int i);
    @(posedge pclk);
    if (i == irq_pkg::SRC_EXT) ext_pin_level <= 1'b1;
    else evt[i] <= 1'b1;
    @(posedge pclk);
    ext_pin_level <= 1'b0;
    evt <= 6'h00;
  endtask : fire

  task automatic expect_take(input int i);
    v = 13'($random(seed));
    next_pc <= v;
    take_q.push_back({irq_pkg::VEC_ADDR[i], v});
  endtask : expect_take

  task automatic ret();
    @(posedge pclk);
    ret_req <= 1'b1;
    @(posedge pclk);
    ret_req <= 1'b0;
    @(posedge pclk);
    cmp("stack pop", 32'h1, {31'h0, stack_pop_ff});
  endtask : ret

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 76;
    {error_cnt, tests_run, cyc} = '0;
    {presetn, psel, penable, pwrite, ext_pin_level, pull_high_sel} = '0;
    {paddr, pwdata, evt, next_pc, boundary_en, ret_req} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < irq_pkg::NUM_REG; i++) rd(i, 8'h00);
    apb(1'b0, 8'h14, 8'h00, 8'h00);
    // refused, must not alias onto the ext two register through paddr[4:2]
    apb(1'b1, 8'h28, 8'hff, 8'h00);
    rd(irq_pkg::REG_TWO, 8'h00);
    wr(irq_pkg::REG_TWO, 8'hff);
    rd(irq_pkg::REG_TWO, 8'hff);
    wr(irq_pkg::REG_THREE, 8'hff);
    rd(irq_pkg::REG_THREE, 8'h11);
    wr(irq_pkg::REG_FIRST, 8'h12);
    rd(irq_pkg::REG_FIRST, 8'h12);
    pull_high_sel <= 1'($random(seed));
    repeat (3) @(posedge pclk);
    cmp("pullup", {31'h0, pull_high_sel}, {31'h0, pull_high_en_ff});
    pull_high_sel <= ~pull_high_sel;
    repeat (3) @(posedge pclk);
    cmp("pullup", {31'h0, pull_high_sel}, {31'h0, pull_high_en_ff});
    for (int i = 0; i < 4; i++) wr(i, 8'h00);
    $display("test registers done");
    // every edge mode, one rise and one fall each
    for (int s = 0; s < 4; s++) begin
      wr(irq_pkg::REG_EDGE, 8'(s));
      ext_pin_level <= 1'b1;
      repeat (3) @(posedge pclk);
      rd(irq_pkg::REG_FIRST, s[0] ? 8'h10 : 8'h00);
      wr(irq_pkg::REG_FIRST, 8'h00);
      ext_pin_level <= 1'b0;
      repeat (3) @(posedge pclk);
      rd(irq_pkg::REG_FIRST, s[1] ? 8'h10 : 8'h00);
      wr(irq_pkg::REG_FIRST, 8'h00);
    end
    $display("test edges done");
    wr(irq_pkg::REG_EDGE, {6'h0, irq_pkg::EDGE_RISE});
    boundary_en <= 1'b1;
    for (int i = 0; i < irq_pkg::NUM_SRC; i++) begin
      r = irq_pkg::SRC_REG[i];
      f = 8'h1 << irq_pkg::FLAG_POS[i];
      n = 8'h1 << irq_pkg::EN_POS[i];
      g = (i == 0) ? 8'h01 : 8'h00;
      wr(irq_pkg::REG_FIRST, 8'h01);
      fire(i);
      repeat (3) @(posedge pclk);
      cmp("wake", 32'h1, {31'h0, wake_ff});
      rd(r, f | g);
      expect_take(i);
      wr(r, f | n | g);
      repeat (3) @(posedge pclk);
      rd(r, n);
      rd(irq_pkg::REG_FIRST, (i == 0) ? n : 8'h00);
      rd(irq_pkg::REG_STATUS, 8'(i) << irq_pkg::ST_SRC_LSB);
      wr(r, 8'h00);
      ret();
      repeat (3) @(posedge pclk);
      cmp("wake", 32'h0, {31'h0, wake_ff});
    end
    $display("test sources done");
    wr(irq_pkg::REG_FIRST, 8'h00);
    wr(irq_pkg::REG_TWO, 8'h09);
    wr(irq_pkg::REG_THREE, 8'h01);
    fire(1);
    fire(4);
    repeat (4) @(posedge pclk);
    rd(irq_pkg::REG_TWO, 8'h99);
    expect_take(1);
    wr(irq_pkg::REG_FIRST, 8'h01);
    repeat (3) @(posedge pclk);
    expect_take(4);
    wr(irq_pkg::REG_FIRST, 8'h01);
    fire(5);
    repeat (3) @(posedge pclk);
    wr(irq_pkg::REG_FIRST, 8'h01);
    repeat (5) @(posedge pclk);
    rd(irq_pkg::REG_THREE, 8'h11);
    // wake, blocked by a full stack, last served source cmpp
    rd(irq_pkg::REG_STATUS, 8'h43);
    expect_take(5);
    ret();
    repeat (3) @(posedge pclk);
    ret();
    ret();
    $display("test priority and stack done");
    cmp("pending notes", 32'h0, 32'(apb_q.size() + take_q.size()));
    final_report();
  end
endmodule : testbench
